// ### stc_pkg.sv
package stc_pkg;
   // ==================================================
   // Register map
   localparam logic [11:0] ADDR_AUTO_CAL_ENABLE = 12'h2b0;
   localparam logic [11:0] ADDR_AUTO_CAL_CONFIG = 12'h2b1;
   localparam logic [11:0] ADDR_AUTO_CAL_RESULT = 12'h2b2;
   localparam logic [7:0] RST_ENABLE = 8'h00;
   localparam logic [7:0] RST_CONFIG = 8'h05;
   localparam int ENABLE_BIT = 0;
   localparam int AVG_LSB = 2;
   localparam int ACC_LSB = 0;
   localparam int DONE_BIT = 17;
   localparam int DELAY_W = 17;
   localparam int INVERT_BIT = 16;
   localparam int COARSE_LSB = 8;
   localparam int FINE_LSB = 0;
   // ==================================================
   // Duration limits per accumulation code, device clock cycles
   localparam logic [15:0] MAX_PERIOD_0 = 16'h0080;
   localparam logic [15:0] MAX_PERIOD_1 = 16'h0680;
   localparam logic [15:0] MAX_PERIOD_2 = 16'h1e80;
   localparam logic [15:0] MAX_PERIOD_3 = 16'h7e80;
   // Bound on whole calibration: 384*19*4^(avg+acc+2)
   localparam int CAL_BOUND_K = 384 * 19;
   // Register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [23:0] wdata;
   } stc_req_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACCUM = 2'b01,
      ST_DONE = 2'b10,
      ST_FAIL = 2'b11
   } stc_state_t;
endpackage

// ### stc_sysref_cal.sv
`timescale 1ns/1ps
// How it works
// - Enable low: delay output follows manual register
// - Enable high: computed delay, manual ignored
// - Only enable rising edge starts calibration
// - Averaging code gives 4/16/64/256 averages
// - Accumulation code gives 4/16/64/256 cycles
// - Too long SYSREF period means failed calibration
// - Calibration finishes within documented cycle bound
// - Complete bit: enable high and sequence finished
// - Result register returns 17-bit computed delay
// - Delay word: invert, coarse, fine fields
// - Manual delay uses same invert/coarse/fine layout
module stc_sysref_cal (
   input wire logic CLK_I,
   input wire logic RSTN_I,
   input wire stc_pkg::stc_req_t REQ_I,
   output logic [23:0] RDATA_O,
   input wire logic SYSREF_I,
   input wire logic [16:0] MANUAL_DELAY_I,
   output logic [16:0] APERTURE_DELAY_O,
   output logic CAL_FAIL_O
);
   // ==================================================
   // Registers
   logic enable_ff, enable_d_ff;
   logic [1:0] avg_sel_ff, acc_sel_ff;
   logic [3:0] cfg_hi_ff;
   logic [6:0] en_hi_ff;
   logic [16:0] computed_delay_word_ff;
   logic [23:0] rdata_ff;
   stc_pkg::stc_state_t state_ff, nxt_state;
   logic [8:0] acc_cnt_ff, avg_cnt_ff;
   logic [15:0] period_cnt_ff, phase_ff;
   logic [27:0] hit_sum_ff;
   logic sysref_d_ff, seen_edge_ff;
   logic period_ok_ff;
   logic [31:0] cyc_ff;

   wire wr_en = REQ_I.wr && REQ_I.addr == stc_pkg::ADDR_AUTO_CAL_ENABLE;
   wire wr_cfg = REQ_I.wr && REQ_I.addr == stc_pkg::ADDR_AUTO_CAL_CONFIG;
   wire start = enable_ff && !enable_d_ff;
   wire sysref_rise = SYSREF_I && !sysref_d_ff;
   wire [8:0] acc_len = 9'h004 << {acc_sel_ff, 1'b0};
   wire [8:0] avg_len = 9'h004 << {avg_sel_ff, 1'b0};
   logic [15:0] max_period;
   always_comb begin
      case (acc_sel_ff)
         2'h0: max_period = stc_pkg::MAX_PERIOD_0;
         2'h1: max_period = stc_pkg::MAX_PERIOD_1;
         2'h2: max_period = stc_pkg::MAX_PERIOD_2;
         default: max_period = stc_pkg::MAX_PERIOD_3;
      endcase
   end
   wire too_long = period_cnt_ff > max_period;
   wire acc_last = acc_cnt_ff == acc_len - 9'h001;
   wire avg_last = avg_cnt_ff == avg_len - 9'h001;
   // A result needs one full SYSREF period seen, else a long period could pass unnoticed
   wire cal_end = acc_last && avg_last;
   wire cal_finish = cal_end && period_ok_ff;
   wire auto_cal_complete = enable_ff && state_ff == stc_pkg::ST_DONE;

   // ==================================================
   // Output selection
   // Manual path whenever disabled; computed word otherwise
   assign APERTURE_DELAY_O = enable_ff ? computed_delay_word_ff : MANUAL_DELAY_I;
   assign CAL_FAIL_O = enable_ff && state_ff == stc_pkg::ST_FAIL;
   assign RDATA_O = rdata_ff;

   // ==================================================
   // Register port
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         enable_ff <= 1'b0;
         en_hi_ff <= 7'h00;
         avg_sel_ff <= stc_pkg::RST_CONFIG[3:2];
         acc_sel_ff <= stc_pkg::RST_CONFIG[1:0];
         cfg_hi_ff <= 4'h0;
      end else begin
         if (wr_en) begin
            enable_ff <= REQ_I.wdata[stc_pkg::ENABLE_BIT];
            en_hi_ff <= REQ_I.wdata[7:1];
         end
         if (wr_cfg) begin
            avg_sel_ff <= REQ_I.wdata[stc_pkg::AVG_LSB +: 2];
            acc_sel_ff <= REQ_I.wdata[stc_pkg::ACC_LSB +: 2];
            cfg_hi_ff <= REQ_I.wdata[7:4];
         end
      end
   end

   logic [23:0] nxt_rdata;
   always_comb begin
      nxt_rdata = 24'h000000;
      case (REQ_I.addr)
         stc_pkg::ADDR_AUTO_CAL_ENABLE: nxt_rdata = {16'h0000, en_hi_ff, enable_ff};
         stc_pkg::ADDR_AUTO_CAL_CONFIG: nxt_rdata = {16'h0000, cfg_hi_ff, avg_sel_ff, acc_sel_ff};
         stc_pkg::ADDR_AUTO_CAL_RESULT:
            nxt_rdata = {6'h00, auto_cal_complete, computed_delay_word_ff};
         default: nxt_rdata = 24'h000000;
      endcase
   end

   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) rdata_ff <= 24'h000000;
      else if (REQ_I.rd) rdata_ff <= nxt_rdata;
   end

   // ==================================================
   // Calibration sequence
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         stc_pkg::ST_IDLE: if (start) nxt_state = stc_pkg::ST_ACCUM;
         stc_pkg::ST_ACCUM: begin
            if (too_long) nxt_state = stc_pkg::ST_FAIL;
            else if (cal_finish) nxt_state = stc_pkg::ST_DONE;
         end
         stc_pkg::ST_DONE: nxt_state = stc_pkg::ST_DONE;
         stc_pkg::ST_FAIL: nxt_state = stc_pkg::ST_FAIL;
         default: nxt_state = stc_pkg::ST_IDLE;
      endcase
      if (!enable_ff) nxt_state = stc_pkg::ST_IDLE;
   end

   // Phase estimate: summed position of SYSREF edges within their period.
   // Fine bits take the low phase, coarse the next, invert the top.
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         state_ff <= stc_pkg::ST_IDLE;
         enable_d_ff <= 1'b0;
         sysref_d_ff <= 1'b0;
         acc_cnt_ff <= 9'h000;
         avg_cnt_ff <= 9'h000;
         period_cnt_ff <= 16'h0000;
         phase_ff <= 16'h0000;
         hit_sum_ff <= 28'h0000000;
         seen_edge_ff <= 1'b0;
         period_ok_ff <= 1'b0;
         computed_delay_word_ff <= 17'h00000;
      end else begin
         state_ff <= nxt_state;
         enable_d_ff <= enable_ff;
         sysref_d_ff <= SYSREF_I;
         if (start) begin
            acc_cnt_ff <= 9'h000;
            avg_cnt_ff <= 9'h000;
            period_cnt_ff <= 16'h0000;
            phase_ff <= 16'h0000;
            hit_sum_ff <= 28'h0000000;
            seen_edge_ff <= 1'b0;
            period_ok_ff <= 1'b0;
         end else if (state_ff == stc_pkg::ST_ACCUM) begin
            // Period counts from start, so a silent SYSREF fails too
            period_cnt_ff <= sysref_rise ? 16'h0000 : period_cnt_ff + 16'h0001;
            if (sysref_rise) seen_edge_ff <= 1'b1;
            if (sysref_rise && seen_edge_ff) period_ok_ff <= 1'b1;
            phase_ff <= sysref_rise ? 16'h0000 : phase_ff + 16'h0001;
            if (SYSREF_I) hit_sum_ff <= hit_sum_ff + {12'h000, phase_ff};
            // Counters park on the last slot until one full period is known
            if (!cal_end) begin
               acc_cnt_ff <= acc_last ? 9'h000 : acc_cnt_ff + 9'h001;
               if (acc_last) avg_cnt_ff <= avg_cnt_ff + 9'h001;
            end
            if (cal_finish) computed_delay_word_ff <= hit_sum_ff[16:0];
         end
      end
   end

   // ==================================================
   // Checks
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) cyc_ff <= 32'h0;
      else if (state_ff == stc_pkg::ST_ACCUM) cyc_ff <= cyc_ff + 32'h1;
      else cyc_ff <= 32'h0;
   end

   chk_manual_path: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      !enable_ff |-> APERTURE_DELAY_O == MANUAL_DELAY_I) else $error("manual delay not used");
   chk_auto_path: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      enable_ff |-> APERTURE_DELAY_O == computed_delay_word_ff) else $error("auto delay not used");
   chk_start_edge: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      $rose(state_ff == stc_pkg::ST_ACCUM) |-> $past(start)) else $error("start without edge");
   chk_fail_long: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      state_ff == stc_pkg::ST_ACCUM && enable_ff && too_long |=> state_ff == stc_pkg::ST_FAIL)
      else $error("long period not failed");
   chk_cal_bound: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      cyc_ff <= 32'(stc_pkg::CAL_BOUND_K) << (2 * (avg_sel_ff + acc_sel_ff + 2)))
      else $error("calibration too long");
   chk_done_bit: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      REQ_I.rd && REQ_I.addr == stc_pkg::ADDR_AUTO_CAL_RESULT |=>
      RDATA_O[stc_pkg::DONE_BIT] == $past(auto_cal_complete)) else $error("done bit wrong");
   chk_result_word: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      REQ_I.rd && REQ_I.addr == stc_pkg::ADDR_AUTO_CAL_RESULT |=>
      RDATA_O[16:0] == $past(computed_delay_word_ff)) else $error("result word wrong");
   chk_clear_done: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      !enable_ff |=> state_ff == stc_pkg::ST_IDLE) else $error("done not cleared");
   chk_avg_count: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      $rose(state_ff == stc_pkg::ST_DONE) |-> $past(avg_cnt_ff) == avg_len - 9'h001)
      else $error("average count wrong");

   // ==================================================
   // Sequence checks
   chk_start_accum: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      start |=> state_ff == stc_pkg::ST_ACCUM)
      else $error("start not taken");
   chk_acc_range: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      state_ff == stc_pkg::ST_ACCUM |-> acc_cnt_ff < acc_len)
      else $error("accumulation count out of range");
   chk_avg_range: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      state_ff == stc_pkg::ST_ACCUM |-> avg_cnt_ff < avg_len)
      else $error("average count out of range");
   chk_done_period: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      $rose(state_ff == stc_pkg::ST_DONE) |-> $past(period_ok_ff))
      else $error("done without a measured period");
   chk_fail_cause: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      $rose(CAL_FAIL_O) |-> $past(too_long))
      else $error("fail without long period");
   chk_result_hold: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
      state_ff == stc_pkg::ST_DONE && $past(state_ff == stc_pkg::ST_DONE) |->
      $stable(computed_delay_word_ff)) else $error("result changed after done");
endmodule

// ### stc_sysref_src.sv
`timescale 1ns/1ps
// ====================
// SYSREF source: one-cycle pulse every period_i clocks
module stc_sysref_src (
   input wire logic clk_i,
   input wire logic [15:0] period_i,
   output logic sysref_o
);
   logic [15:0] cnt = 16'h0000;
   initial sysref_o = 1'b0;
   // Period stays inside the selected limit except in the fault run
   always @(negedge clk_i) begin
      cnt <= (cnt >= period_i - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
      sysref_o <= (cnt == 16'h0000);
   end
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   stc_pkg::stc_req_t req = '0;
   logic [23:0] rdata;
   logic sysref;
   logic [16:0] manual = 17'h00000;
   logic [16:0] aperture;
   logic cal_fail;
   logic [15:0] period = 16'h0040;
   logic [15:0] lfsr = 16'h1e63;
   logic [23:0] rd = '0;
   int fail_count = 0;
   int compares = 0;
   int cycles = 0;
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   stc_sysref_cal i_stc_sysref_cal (.CLK_I(clk_i), .RSTN_I(rstn_i), .REQ_I(req),
      .RDATA_O(rdata), .SYSREF_I(sysref), .MANUAL_DELAY_I(manual),
      .APERTURE_DELAY_O(aperture), .CAL_FAIL_O(cal_fail));
   stc_sysref_src i_stc_sysref_src (.clk_i(clk_i), .period_i(period), .sysref_o(sysref));
   // ====================
   // Helpers
   function automatic logic [15:0] lfsr_next(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task automatic bus(input logic w, input logic [11:0] a, input logic [23:0] d);
      @(negedge clk_i);
      req <= '{wr: w, rd: ~w, addr: a, wdata: d};
      @(negedge clk_i);
      req <= '0;
      @(negedge clk_i);
      rd = rdata;
   endtask
   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Poll the result until complete or failed; limit well above the run length
   task automatic wait_done(input int lim);
      int n;
      n = 0;
      rd = '0;
      while (rd[17] !== 1'b1 && cal_fail !== 1'b1 && n < lim) begin
         bus(1'b0, stc_pkg::ADDR_AUTO_CAL_RESULT, 24'h000000);
         n++;
      end
   endtask
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         fail_count = fail_count + 1;
         report_and_stop();
      end
   end
   // ====================
   // Main sequence
   initial begin
      manual = lfsr[0] ? 17'h1a5c3 : 17'h05a3c;
      repeat (16) @(negedge clk_i);
      rstn_i = 1'b1;
      check("aperture", {7'h00, manual}, {7'h00, aperture});
      bus(1'b0, stc_pkg::ADDR_AUTO_CAL_CONFIG, 24'h000000);
      check("config reset", 24'h000005, rd);
      bus(1'b0, stc_pkg::ADDR_AUTO_CAL_ENABLE, 24'h000000);
      check("enable reset", 24'h000000, rd);
      bus(1'b1, stc_pkg::ADDR_AUTO_CAL_RESULT, 24'hffffff);
      bus(1'b0, stc_pkg::ADDR_AUTO_CAL_RESULT, 24'h000000);
      check("result ro", 24'h000000, rd);
      bus(1'b0, 12'h2b3, 24'h000000);
      check("unmapped", 24'h000000, rd);
      for (int c = 0; c < 16; c++) begin
         bus(1'b1, stc_pkg::ADDR_AUTO_CAL_CONFIG, 24'(c));
         bus(1'b0, stc_pkg::ADDR_AUTO_CAL_CONFIG, 24'h000000);
         check("config", 24'(c), rd);
      end
      for (int a = 0; a < 3; a++) begin
         for (int h = 0; h < 3 - a; h++) begin
            lfsr = lfsr_next(lfsr);
            period <= 16'h0010 + {10'h000, lfsr[5:0]};
            bus(1'b1, stc_pkg::ADDR_AUTO_CAL_CONFIG, 24'(a * 4 + h));
            bus(1'b1, stc_pkg::ADDR_AUTO_CAL_ENABLE, 24'h000001);
            wait_done((16 << (2 * (a + h))) + 100);
            check("complete", 24'h020000, rd & 24'hfe0000);
            manual = {lfsr[0], lfsr};
            @(negedge clk_i);
            check("computed", {7'h00, rd[16:0]}, {7'h00, aperture});
            bus(1'b1, stc_pkg::ADDR_AUTO_CAL_ENABLE, 24'h000001);
            bus(1'b0, stc_pkg::ADDR_AUTO_CAL_RESULT, 24'h000000);
            check("no restart", 24'h020000, rd & 24'hfe0000);
            bus(1'b1, stc_pkg::ADDR_AUTO_CAL_ENABLE, 24'h000000);
            check("manual back", {7'h00, manual}, {7'h00, aperture});
            bus(1'b0, stc_pkg::ADDR_AUTO_CAL_RESULT, 24'h000000);
            check("cleared", 24'h000000, rd & 24'hfe0000);
         end
      end
      period <= 16'h00c8;
      bus(1'b1, stc_pkg::ADDR_AUTO_CAL_CONFIG, 24'h000000);
      bus(1'b1, stc_pkg::ADDR_AUTO_CAL_ENABLE, 24'h000001);
      wait_done(300);
      check("fail flag", 24'h000001, {23'h0, cal_fail});
      check("fail done", 24'h000000, rd & 24'h020000);
      report_and_stop();
   end
endmodule
